// >>> common/cdhc_map.svh
// constants of the debug halt control
// What this block does
// - entry saves pc, cause; jumps halt vector
// - enter on request, trigger, enabled breakpoint
// - decode instruction at request not executed
// - three status outputs exactly one high
// - reset-seen high in reset, clears after go
// - afterwards halted in debug, else running
// - unavailable until release and go seen
// - early request goes straight to halted
// - request while running reaches halted soon
// - breakpoint in debug re-enters halt vector
// - exception in debug jumps exception vector
// - trap return in debug jumps exception vector
// - debug registers illegal outside debug mode
// - one trigger, instruction address match only
// - trigger dmode field reads constant one
// - trigger writes ignored outside debug, reads ok
// - pc-dependent or buffer jumps never illegal
// - interrupts ignored while in debug mode
`ifndef CDHC_MAP_SVH
`define CDHC_MAP_SVH
// bus register offsets
`define CDHC_OFF_CTRL     8'h00
`define CDHC_OFF_STATUS   8'h04
`define CDHC_OFF_DPC      8'h08
// control field positions and reset
`define CDHC_CTRL_TRIGEN  0
`define CDHC_CTRL_SWHALT  1
`define CDHC_CTRL_TRIGEN_RST 1'b1
// core-side register addresses
`define CDHC_CSR_DCSR     12'h7b0
`define CDHC_CSR_DPC      12'h7b1
`define CDHC_CSR_DSCR0    12'h7b2
`define CDHC_CSR_DSCR1    12'h7b3
`define CDHC_CSR_TSEL     12'h7a0
`define CDHC_CSR_TDATA1   12'h7a1
`define CDHC_CSR_TDATA2   12'h7a2
`define CDHC_CSR_TINFO    12'h7a4
// field positions and constants
`define CDHC_DCSR_EBREAKM 15
`define CDHC_TD1_EXEC     2
`define CDHC_DEBUG_VER    4'h4
`define CDHC_TRIG_TYPE    4'h2
`define CDHC_TINFO_VAL    32'h0000_0004
`define CDHC_EBREAKM_RST  1'b0
// entry cause codes
`define CDHC_CAUSE_EBREAK 3'h1
`define CDHC_CAUSE_TRIG   3'h2
`define CDHC_CAUSE_HALT   3'h3
// bus responses
`define CDHC_RESP_OKAY    2'h0
`define CDHC_RESP_SLVERR  2'h2
`endif

// >>> common/cdhc_pkg.sv
// debug halt control types
package cdhc_pkg;
    // **
    // debug availability states
    // **
    typedef enum logic [1:0] {ST_UNAVAIL, ST_RUN, ST_HALT} cdhc_state_e_t;

    // decode stage view of the core
    typedef struct packed {
        logic        valid;    // instruction present
        logic [31:0] pc;       // its address
        logic        isEbreak; // breakpoint instruction
        logic        isMret;   // mret or uret
        logic        isDret;   // return from debug
        logic        excp;     // exception raised
    } cdhc_dec_t;

    // core register access request and answer
    typedef struct packed {
        logic        valid;
        logic [11:0] addr;
        logic        write;
        logic [31:0] wdata;
    } cdhc_csr_req_t;
    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
        logic        illegal;
    } cdhc_csr_rsp_t;

    // fetch redirect
    typedef struct packed {
        logic        valid;
        logic [31:0] target;
        logic        flush;
    } cdhc_pc_set_t;

    // axi4-lite master to slave
    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } cdhc_axi_req_t;
    // axi4-lite slave to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cdhc_axi_rsp_t;

    // synchroniser state
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic out;
    } cdhc_sync_t;
endpackage

// >>> rtl/cdhc_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module cdhc_sync3 (
    input  wire logic sys_clk, // core clock
    input  wire logic sys_rst, // synchronous reset, high
    input  wire logic din,     // asynchronous level
    output logic      dout     // filtered level
);
    // **
    // state
    // **
    cdhc_pkg::cdhc_sync_t s; // current
    cdhc_pkg::cdhc_sync_t n; // next

    // shift; output follows when stages 2,3 agree
    always_comb begin
        n = s;
        n.s1 = din;
        n.s2 = s.s1;
        n.s3 = s.s2;
        if (s.s2 == s.s3) begin
            n.out = s.s3;
        end
    end

    // register the state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign dout = s.out;
endmodule

// >>> rtl/cdhc_debug_ctrl.sv
// debug mode entry, exit and debug register control for the core
`timescale 1ns/10ps
`include "cdhc_map.svh"
module cdhc_debug_ctrl (
    input  wire logic                    sys_clk,              // core clock
    input  wire logic                    sys_rst,              // sync reset, high
    input  wire logic                    haltRequest,          // debug request
    input  wire logic                    fetchGo,              // fetch enable pin
    input  wire logic [31:0]             bootAddr,             // first fetch address
    input  wire logic [31:0]             haltEntryVector,      // debug entry address
    input  wire logic [31:0]             debugExceptionVector, // debug trap address
    input  wire cdhc_pkg::cdhc_dec_t     decode,               // decode stage view
    input  wire cdhc_pkg::cdhc_csr_req_t csrReq,               // register access
    output cdhc_pkg::cdhc_csr_rsp_t      csrRsp,               // access answer
    output cdhc_pkg::cdhc_pc_set_t       pcSet,                // fetch redirect
    output logic                         debugMode,            // in debug mode
    output logic                         irqIgnore,            // mask interrupts
    output logic                         resetSeen,            // status: reset
    output logic                         running,              // status: running
    output logic                         halted,               // status: halted
    input  wire cdhc_pkg::cdhc_axi_req_t axiReq,               // bus request
    output cdhc_pkg::cdhc_axi_rsp_t      axiRsp                // bus answer
);
    // **
    // state record
    // **
    typedef struct packed {
        cdhc_pkg::cdhc_state_e_t st;         // availability state
        logic                    pendHalt;   // request seen before go
        logic                    ebreakm;    // breakpoint enters debug
        logic [2:0]              cause;      // last entry cause
        logic [31:0]             dpc;        // saved pc
        logic [31:0]             scratch0;   // debug scratch 0
        logic [31:0]             scratch1;   // debug scratch 1
        logic                    trigExec;   // trigger armed
        logic [31:0]             trigAddr;   // trigger match address
        logic                    ctrlTrigEn; // bus trigger enable
        logic                    ctrlSwHalt; // bus halt request
        logic                    awTaken;    // write address held
        logic [7:0]              awAddr;     // held write address
        logic                    wTaken;     // write data held
        logic [31:0]             wData;      // held write data
        logic [3:0]              wStrb;      // held byte strobes
        cdhc_pkg::cdhc_axi_rsp_t axi;        // bus answer
        cdhc_pkg::cdhc_pc_set_t  pc;         // redirect
        cdhc_pkg::cdhc_csr_rsp_t csr;        // access answer
        logic                    resetSeen;  // status out
        logic                    running;    // status out
        logic                    halted;     // status out
        logic                    irqIgnore;  // interrupt mask out
    } cdhc_regs_t;

    cdhc_regs_t s;      // current state
    cdhc_regs_t n;      // next state
    logic       goSync; // filtered fetch enable
    logic       inDebug;  // currently halted
    logic       trigHit;  // instruction address match
    logic       brkEntry; // breakpoint enters debug
    logic       reqEntry; // external or bus request
    logic [31:0] dcsrVal; // assembled dcsr
    logic [31:0] td1Val;  // assembled trigger data 1

    // **
    // fetch enable pin crossing
    // **
    cdhc_sync3 u_go_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .din     (fetchGo),
        .dout    (goSync)
    );

    // **
    // entry conditions and register images
    // **
    // entry events while running
    always_comb begin
        inDebug = (s.st == cdhc_pkg::ST_HALT);
        // single trigger, execute address compare only
        trigHit = s.ctrlTrigEn && s.trigExec && decode.valid
                  && (decode.pc == s.trigAddr);
        brkEntry = decode.valid && decode.isEbreak && s.ebreakm;
        reqEntry = haltRequest || s.ctrlSwHalt;
        // dcsr: version, ebreakm, cause, machine privilege
        dcsrVal = {`CDHC_DEBUG_VER, 12'h000, s.ebreakm, 6'h00, s.cause,
                   4'h0, 2'b11};
        // trigger data 1: type, dmode fixed one, m, execute
        td1Val = {`CDHC_TRIG_TYPE, 1'b1, 20'h00000, 1'b1, 3'h0, s.trigExec,
                  2'h0};
    end

    // **
    // next state
    // **
    always_comb begin
        n = s;
        // one-cycle pulses drop by default
        n.pc.valid = 1'b0;
        n.pc.flush = 1'b0;
        n.csr.valid = 1'b0;
        n.csr.illegal = 1'b0;

        // core register accesses, answered next cycle
        if (csrReq.valid) begin
            n.csr.valid = 1'b1;
            n.csr.rdata = 32'h0000_0000;
            case (csrReq.addr)
                `CDHC_CSR_DCSR: begin
                    n.csr.rdata = dcsrVal;
                    if (!inDebug) begin
                        n.csr.illegal = 1'b1;
                    end else if (csrReq.write) begin
                        n.ebreakm = csrReq.wdata[`CDHC_DCSR_EBREAKM];
                    end
                end
                `CDHC_CSR_DPC: begin
                    n.csr.rdata = s.dpc;
                    if (!inDebug) begin
                        n.csr.illegal = 1'b1;
                    end else if (csrReq.write) begin
                        n.dpc = csrReq.wdata;
                    end
                end
                `CDHC_CSR_DSCR0: begin
                    n.csr.rdata = s.scratch0;
                    if (!inDebug) begin
                        n.csr.illegal = 1'b1;
                    end else if (csrReq.write) begin
                        n.scratch0 = csrReq.wdata;
                    end
                end
                `CDHC_CSR_DSCR1: begin
                    n.csr.rdata = s.scratch1;
                    if (!inDebug) begin
                        n.csr.illegal = 1'b1;
                    end else if (csrReq.write) begin
                        n.scratch1 = csrReq.wdata;
                    end
                end
                `CDHC_CSR_TSEL: begin
                    n.csr.rdata = 32'h0000_0000; // only trigger zero
                end
                `CDHC_CSR_TDATA1: begin
                    n.csr.rdata = td1Val;
                    if (inDebug && csrReq.write) begin
                        n.trigExec = csrReq.wdata[`CDHC_TD1_EXEC];
                    end
                end
                `CDHC_CSR_TDATA2: begin
                    n.csr.rdata = s.trigAddr;
                    if (inDebug && csrReq.write) begin
                        n.trigAddr = csrReq.wdata;
                    end
                end
                `CDHC_CSR_TINFO: begin
                    n.csr.rdata = `CDHC_TINFO_VAL;
                end
                default: begin
                    // core-owned, never illegal
                    n.csr.rdata = 32'h0000_0000;
                end
            endcase
        end

        // availability state machine
        case (s.st)
            cdhc_pkg::ST_UNAVAIL: begin
                // request seen before fetch enable
                if (haltRequest) begin
                    n.pendHalt = 1'b1;
                end
                if (goSync) begin
                    if (s.pendHalt || reqEntry) begin
                        // straight to halted, never running
                        n.st = cdhc_pkg::ST_HALT;
                        n.dpc = bootAddr;
                        n.cause = `CDHC_CAUSE_HALT;
                        n.pc.valid = 1'b1;
                        n.pc.target = haltEntryVector;
                        n.pc.flush = 1'b1;
                        n.ctrlSwHalt = 1'b0;
                    end else begin
                        n.st = cdhc_pkg::ST_RUN;
                    end
                    n.pendHalt = 1'b0;
                end
            end
            cdhc_pkg::ST_RUN: begin
                // priority: trigger, break, request
                if (trigHit || brkEntry || reqEntry) begin
                    n.st = cdhc_pkg::ST_HALT;
                    // decode slot flushed, resumed at dpc
                    n.dpc = decode.pc;
                    if (trigHit) begin
                        n.cause = `CDHC_CAUSE_TRIG;
                    end else if (brkEntry) begin
                        n.cause = `CDHC_CAUSE_EBREAK;
                    end else begin
                        n.cause = `CDHC_CAUSE_HALT;
                    end
                    n.pc.valid = 1'b1;
                    n.pc.target = haltEntryVector;
                    n.pc.flush = 1'b1;
                    n.ctrlSwHalt = 1'b0;
                end
            end
            cdhc_pkg::ST_HALT: begin
                if (decode.valid && decode.excp) begin
                    // any fault inside debug code
                    n.pc.valid = 1'b1;
                    n.pc.target = debugExceptionVector;
                    n.pc.flush = 1'b1;
                end else if (decode.valid && decode.isMret) begin
                    // trap return leaves status untouched
                    n.pc.valid = 1'b1;
                    n.pc.target = debugExceptionVector;
                    n.pc.flush = 1'b1;
                end else if (decode.valid && decode.isEbreak) begin
                    // restart debug code, registers kept
                    n.pc.valid = 1'b1;
                    n.pc.target = haltEntryVector;
                    n.pc.flush = 1'b1;
                end else if (decode.valid && decode.isDret) begin
                    // resume at saved pc
                    n.st = cdhc_pkg::ST_RUN;
                    n.pc.valid = 1'b1;
                    n.pc.target = n.dpc;
                    n.pc.flush = 1'b1;
                end
            end
            default: begin
                n.st = cdhc_pkg::ST_UNAVAIL;
            end
        endcase

        // **
        // axi4-lite write channel
        // **
        if (s.axi.awready && axiReq.awvalid) begin
            n.awTaken = 1'b1;
            n.awAddr = axiReq.awaddr;
        end
        if (s.axi.wready && axiReq.wvalid) begin
            n.wTaken = 1'b1;
            n.wData = axiReq.wdata;
            n.wStrb = axiReq.wstrb;
        end
        if (s.axi.bvalid && axiReq.bready) begin
            n.axi.bvalid = 1'b0;
        end
        // write once address and data held
        if (n.awTaken && n.wTaken && !n.axi.bvalid) begin
            n.axi.bvalid = 1'b1;
            n.axi.bresp = `CDHC_RESP_OKAY;
            n.awTaken = 1'b0;
            n.wTaken = 1'b0;
            case ({n.awAddr[7:2], 2'b00})
                `CDHC_OFF_CTRL: begin
                    // software write wins over hardware clear
                    if (n.wStrb[0]) begin
                        n.ctrlTrigEn = n.wData[`CDHC_CTRL_TRIGEN];
                        n.ctrlSwHalt = n.wData[`CDHC_CTRL_SWHALT];
                    end
                end
                `CDHC_OFF_STATUS, `CDHC_OFF_DPC: begin
                    // read-only, write dropped
                    n.axi.bresp = `CDHC_RESP_OKAY;
                end
                default: begin
                    n.axi.bresp = `CDHC_RESP_SLVERR;
                end
            endcase
        end
        n.axi.awready = !n.awTaken && !n.axi.bvalid;
        n.axi.wready = !n.wTaken && !n.axi.bvalid;

        // **
        // axi4-lite read channel
        // **
        if (s.axi.rvalid && axiReq.rready) begin
            n.axi.rvalid = 1'b0;
        end
        if (s.axi.arready && axiReq.arvalid) begin
            n.axi.rvalid = 1'b1;
            n.axi.rresp = `CDHC_RESP_OKAY;
            case ({axiReq.araddr[7:2], 2'b00})
                `CDHC_OFF_CTRL: begin
                    n.axi.rdata = {30'h0000_0000, s.ctrlSwHalt, s.ctrlTrigEn};
                end
                `CDHC_OFF_STATUS: begin
                    n.axi.rdata = {26'h000_0000, s.cause, s.halted, s.running,
                                   s.resetSeen};
                end
                `CDHC_OFF_DPC: begin
                    n.axi.rdata = s.dpc;
                end
                default: begin
                    n.axi.rdata = 32'h0000_0000;
                    n.axi.rresp = `CDHC_RESP_SLVERR;
                end
            endcase
        end
        n.axi.arready = !n.axi.rvalid;

        // **
        // status outputs from next state
        // **
        n.resetSeen = (n.st == cdhc_pkg::ST_UNAVAIL);
        n.running = (n.st == cdhc_pkg::ST_RUN);
        n.halted = (n.st == cdhc_pkg::ST_HALT);
        n.irqIgnore = (n.st != cdhc_pkg::ST_RUN);
    end

    // **
    // state register
    // **
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s <= '0;
            s.st <= cdhc_pkg::ST_UNAVAIL;
            s.resetSeen <= 1'b1;
            s.irqIgnore <= 1'b1;
            s.ebreakm <= `CDHC_EBREAKM_RST;
            s.ctrlTrigEn <= `CDHC_CTRL_TRIGEN_RST;
        end else begin
            s <= n;
        end
    end

    // **
    // outputs, all straight from flops
    // **
    assign csrRsp = s.csr;
    assign pcSet = s.pc;
    assign debugMode = s.halted;
    assign irqIgnore = s.irqIgnore;
    assign resetSeen = s.resetSeen;
    assign running = s.running;
    assign halted = s.halted;
    assign axiRsp = s.axi;
endmodule

// >>> verif/cdhc_chk.sv
// port assertions for the debug halt control
`timescale 1ns/10ps
module cdhc_chk (
    input wire logic                    sys_clk,              // core clock
    input wire logic                    sys_rst,              // sync reset
    input wire logic                    haltRequest,          // debug request
    input wire logic                    fetchGo,              // fetch enable
    input wire logic [31:0]             haltEntryVector,      // entry address
    input wire logic [31:0]             debugExceptionVector, // trap address
    input wire cdhc_pkg::cdhc_dec_t     decode,               // decode view
    input wire cdhc_pkg::cdhc_csr_req_t csrReq,               // register access
    input wire cdhc_pkg::cdhc_csr_rsp_t csrRsp,               // access answer
    input wire cdhc_pkg::cdhc_pc_set_t  pcSet,                // fetch redirect
    input wire logic                    debugMode,            // in debug
    input wire logic                    irqIgnore,            // irq mask
    input wire logic                    resetSeen,            // status reset
    input wire logic                    running,              // status run
    input wire logic                    halted                // status halt
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    property p_one; $onehot({resetSeen, running, halted}); endproperty
    property p_rst; disable iff (1'b0) sys_rst |=> resetSeen; endproperty
    property p_wait; (resetSeen && !fetchGo) [*3] |=> resetSeen; endproperty
    property p_halt; running && haltRequest |=> halted && pcSet.valid && pcSet.flush
        && pcSet.target == $past(haltEntryVector); endproperty
    property p_mode; halted |-> debugMode && irqIgnore; endproperty
    property p_ill; csrReq.valid && !debugMode && csrReq.addr[11:2] == 10'h1ec
        |=> csrRsp.valid && csrRsp.illegal; endproperty
    property p_trg; csrReq.valid && csrReq.addr[11:4] == 8'h7a |=> !csrRsp.illegal; endproperty
    property p_exc; halted && decode.valid && decode.excp
        |=> pcSet.valid && pcSet.target == $past(debugExceptionVector); endproperty
    property p_ret; halted && decode.valid && !decode.excp && decode.isMret
        |=> halted && pcSet.target == $past(debugExceptionVector); endproperty
    property p_brk; halted && decode.valid && !decode.excp && !decode.isMret && decode.isEbreak
        |=> halted && pcSet.target == $past(haltEntryVector); endproperty
    a_one: assert property (p_one) else $error("status not one-hot");
    a_rst: assert property (p_rst) else $error("reset-seen low in reset");
    a_wait: assert property (p_wait) else $error("left unavailable early");
    a_halt: assert property (p_halt) else $error("halt entry wrong");
    a_mode: assert property (p_mode) else $error("halt without mask");
    a_ill: assert property (p_ill) else $error("debug reg not illegal");
    a_trg: assert property (p_trg) else $error("trigger reg illegal");
    a_exc: assert property (p_exc) else $error("debug trap target wrong");
    a_ret: assert property (p_ret) else $error("trap return target wrong");
    a_brk: assert property (p_brk) else $error("debug break target wrong");
    c_halt: cover property (running && haltRequest);
    c_exc: cover property (halted && decode.valid && decode.excp);
    c_early: cover property (resetSeen ##1 halted);
endmodule
bind cdhc_debug_ctrl cdhc_chk cdhc_chk_inst (.*);

// >>> verif/cdhc_dm_model.sv
// far-side debug module: halt request and vectors
`timescale 1ns/10ps
module cdhc_dm_model (
    input  wire logic   sys_clk,             // core clock
    input  wire logic   sys_rst,             // sync reset
    input  wire logic   go,                  // bench asks for a halt
    input  wire logic   halted,              // core status
    output logic        haltRequest,         // request to core
    output logic [31:0] haltEntryVector,     // entry address
    output logic [31:0] debugExceptionVector // trap address
);
    logic hold_q; // request kept until halt seen
    // same-clock request held until the core reports halted
    always_ff @(posedge sys_clk) begin
        if (sys_rst || halted) hold_q <= 1'b0;
        else if (go) hold_q <= 1'b1;
    end
    assign haltRequest = go | hold_q;
    assign haltEntryVector = 32'h0000_0800; // word aligned
    assign debugExceptionVector = 32'h0000_0808; // word aligned
endmodule

// >>> verif/testbench.sv
// self-checking bench for the debug halt control
`timescale 1ns/10ps
`include "cdhc_map.svh"
module testbench;
    localparam logic [31:0] BOOT = 32'h0000_0080; // first fetch
    localparam logic [31:0] TRG = 32'h0000_0100; // trigger address
    logic sys_clk = 1'b0, sys_rst = 1'b1, fetchGo = 1'b0, go = 1'b0, il; // drives, illegal
    logic haltRequest, debugMode, irqIgnore, resetSeen, running, halted; // status
    logic [31:0] hv, ev, rd; // vectors, read data
    logic [1:0] rs; // bus response
    cdhc_pkg::cdhc_dec_t     decode = '0; // decode stage
    cdhc_pkg::cdhc_csr_req_t csrReq = '0; // register access
    cdhc_pkg::cdhc_axi_req_t axiReq = '0; // bus request
    cdhc_pkg::cdhc_csr_rsp_t csrRsp;
    cdhc_pkg::cdhc_pc_set_t  pcSet;
    cdhc_pkg::cdhc_axi_rsp_t axiRsp;
    int err_total = 0, cmp_count = 0; // counts
    always #25 sys_clk = ~sys_clk;
    cdhc_dm_model cdhc_dm_model_inst (.*, .haltEntryVector(hv), .debugExceptionVector(ev));
    cdhc_debug_ctrl cdhc_debug_ctrl_inst (.*, .bootAddr(BOOT), .haltEntryVector(hv),
        .debugExceptionVector(ev));
    // **
    // access tasks
    // **
    task automatic chk(input string n, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [31:0] dx(input logic e, input logic [2:0] c);
        return {4'h4, 12'h0, e, 6'h0, c, 4'h0, 2'b11};
    endfunction
    task automatic csr(input logic [11:0] a, input logic w, input logic [31:0] d);
        csrReq <= '{1'b1, a, w, d};
        @(posedge sys_clk);
        csrReq.valid <= 1'b0;
        #1 rd = csrRsp.rdata;
        il = csrRsp.illegal;
    endtask
    task automatic cr(input string n, input logic [11:0] a, input logic [31:0] e);
        csr(a, 1'b0, 32'h0);
        chk(n, e, rd);
    endtask
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
        cdhc_pkg::cdhc_axi_rsp_t r; // answer before the edge
        axiReq <= '{w, a, w, d, 4'hf, w, !w, a, !w};
        repeat (20) begin
            @(negedge sys_clk) r = axiRsp;
            @(posedge sys_clk);
            if (r.awready) axiReq.awvalid <= 1'b0;
            if (r.wready) axiReq.wvalid <= 1'b0;
            if (r.arready) axiReq.arvalid <= 1'b0;
            if (r.bvalid || r.rvalid) begin
                axiReq.bready <= 1'b0;
                axiReq.rready <= 1'b0;
                rd = r.rdata;
                rs = w ? r.bresp : r.rresp;
                break;
            end
        end
        chk("bus answer", 32'h1, {31'h0, r.bvalid | r.rvalid});
        #1;
    endtask
    // one decode cycle, k = ebreak, mret, dret, exception
    task automatic dec(input logic [31:0] pc, input logic [3:0] k);
        decode <= {1'b1, pc, k};
        @(posedge sys_clk);
        decode <= '0;
        #1;
    endtask
    task automatic resume(input logic [31:0] p);
        dec(32'h0, 4'b0010);
        chk("running", 32'h1, {31'h0, running});
        chk("resume pc", p, pcSet.target);
        $display("step done, mismatches %0d", err_total);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // **
    // tests
    // **
    initial begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        axi(1'b0, `CDHC_OFF_CTRL, 32'h0);
        chk("ctrl reset", 32'h1, rd);
        axi(1'b0, 8'h0c, 32'h0);
        chk("unmapped", 32'h2, {30'h0, rs});
        chk("reset seen", 32'h1, {31'h0, resetSeen});
        fetchGo <= 1'b1;
        for (int i = 0; i < 20 && resetSeen !== 1'b0; i++) @(posedge sys_clk);
        #1 chk("early halt", 32'h1, {31'h0, halted});
        cr("dcsr", `CDHC_CSR_DCSR, dx(1'b0, 3'h3));
        cr("dpc", `CDHC_CSR_DPC, BOOT);
        csr(`CDHC_CSR_DCSR, 1'b1, 32'h0000_8000);
        csr(`CDHC_CSR_TDATA2, 1'b1, TRG);
        csr(`CDHC_CSR_TDATA1, 1'b1, 32'h4);
        csr(`CDHC_CSR_DSCR1, 1'b1, 32'h5a5a_0001);
        cr("scratch", `CDHC_CSR_DSCR1, 32'h5a5a_0001);
        cr("tdata1", `CDHC_CSR_TDATA1, 32'h2800_0044);
        dec(32'h40, 4'b1000);
        chk("brk pc", hv, pcSet.target);
        cr("dcsr kept", `CDHC_CSR_DCSR, dx(1'b1, 3'h3));
        dec(32'h44, 4'b0100);
        chk("mret pc", ev, pcSet.target);
        dec(32'h48, 4'b0001);
        chk("excp pc", ev, pcSet.target);
        resume(BOOT);
        csr(`CDHC_CSR_DPC, 1'b0, 32'h0);
        chk("illegal", 32'h1, {31'h0, il});
        csr(`CDHC_CSR_TDATA2, 1'b1, 32'h0);
        cr("tdata2", `CDHC_CSR_TDATA2, TRG);
        dec(TRG, 4'b0000);
        cr("trig cause", `CDHC_CSR_DCSR, dx(1'b1, 3'h2));
        resume(TRG);
        dec(32'h200, 4'b1000);
        cr("brk cause", `CDHC_CSR_DCSR, dx(1'b1, 3'h1));
        resume(32'h200);
        go <= 1'b1;
        dec(32'h300, 4'b0000);
        go <= 1'b0;
        chk("flush", 32'h1, {31'h0, pcSet.flush});
        cr("halt dpc", `CDHC_CSR_DPC, 32'h300);
        resume(32'h300);
        axi(1'b1, `CDHC_OFF_CTRL, 32'h3);
        for (int i = 0; i < 20 && halted !== 1'b1; i++) @(posedge sys_clk);
        #1 axi(1'b0, `CDHC_OFF_STATUS, 32'h0);
        chk("status", 32'h1c, rd);
        axi(1'b0, `CDHC_OFF_CTRL, 32'h0);
        chk("ctrl clear", 32'h1, rd);
        resume(32'h0);
        complete_run;
    end
    initial begin
        #100us;
        err_total++;
        $display("[ERR] watchdog expected finish seen hang");
        complete_run;
    end
endmodule
